// ==== design/ssa_top.sv ====
// Purpose: Station address and line setup front end of a multidrop serial slave
// Assumes: Inputs synchronous to clock_i; the protocol engine reports requests and detection
// Notes: Long times are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
`include "ssa_consts.svh"
// What this block does
// - Station address counts as valid only within 1 to 247.
// - A switch change stops answers to the old address at once.
// - New address applies after switches stay still 15 s; changes restart wait.
// - Invalid address makes the red LED blink once, repeatedly.
// - Display shows active address from power-on, or error when invalid.
// - Invalid address at power-on shows the address error indication.
// - Option switch position 4 turns automatic line detection on or off.
// - Binary framing: 8 data bits, even/odd parity 1 stop, or none 2 stop.
// - Text framing: 7 data bits, even/odd parity 1 stop, or none 2 stop.
// - Line rate is one of 9600 to 115200 in six fixed steps.
// - Detection off: fixed binary 8N1, baud rate still detected.
// - Detection ends on a good request to us; settings saved, reused later.
// - Address is 8-bit binary, switch position 1 weight 128, position 8 weight 1.
module ssa_top #(
   parameter int unsigned SETTLE_CYC = `SSA_SETTLE_S * `SSA_CLK_HZ,
   parameter int unsigned BLINK_CYC = `SSA_BLINK_PERIOD_MS * (`SSA_CLK_HZ / 1000),
   parameter int unsigned BLINK_ON_CYC = `SSA_BLINK_ON_MS * (`SSA_CLK_HZ / 1000)
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Switch banks, index 7 is position 1
   input wire logic [7:0] address_switch_bank_i,
   input wire logic [7:0] option_switch_bank_i,
   // Stored line setup loaded at start-up
   input wire logic nv_valid_i,
   input wire ssa_pkg::ssa_mode_t nv_mode_i,
   input wire ssa_pkg::ssa_par_t nv_parity_i,
   input wire logic nv_stop2_i,
   input wire logic [2:0] nv_baud_i,
   // Line setup seen by the detector
   input wire ssa_pkg::ssa_mode_t det_mode_i,
   input wire ssa_pkg::ssa_par_t det_parity_i,
   input wire logic det_stop2_i,
   input wire logic [2:0] det_baud_i,
   // Received request from the protocol engine
   input wire logic req_valid_i,
   input wire logic [7:0] req_addr_i,
   input wire logic req_ok_i,
   // Answer permission
   output logic answer_o,
   // Indicators
   output logic led_red_o,
   output logic [7:0] disp_addr_o,
   output logic disp_err_o,
   // Line setup in use
   output logic detecting_o,
   output var ssa_pkg::ssa_mode_t cfg_mode_o,
   output var ssa_pkg::ssa_par_t cfg_parity_o,
   output logic cfg_stop2_o,
   output logic [2:0] cfg_baud_o,
   output logic [3:0] cfg_data_bits_o,
   output logic cfg_legal_o,
   output logic nv_save_o
);
   ssa_pkg::ssa_state_t cur_ff;
   ssa_pkg::ssa_state_t nxt_cur;
   logic line_ok;
   logic [3:0] dbits;
   logic sw_ok;
   logic sw_moved;

   // ==========================================================
   // Line setting check
   ssa_line_check u_check (
      .mode_i(cur_ff.mode),
      .parity_i(cur_ff.par),
      .stop2_i(cur_ff.stop2),
      .baud_i(cur_ff.baud),
      .allow_8n1_i(!cur_ff.auto_full),
      .legal_o(line_ok),
      .data_bits_o(dbits)
   );

   // ==========================================================
   // Next state
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.save = 1'b0;
      // Switch value is already plain binary with position 1 as MSB
      sw_ok = (address_switch_bank_i >= `SSA_ADDR_MIN) &&
              (address_switch_bank_i <= `SSA_ADDR_MAX);
      sw_moved = address_switch_bank_i != cur_ff.last_sw;
      nxt_cur.last_sw = address_switch_bank_i;
      case (cur_ff.det)
         ssa_pkg::SSA_DET_INIT: begin
            // Straps caught once, at the first edge after reset release
            nxt_cur.active = address_switch_bank_i;
            nxt_cur.ok = sw_ok;
            nxt_cur.auto_full = option_switch_bank_i[`SSA_OPT_AUTODET_BIT];
            if (nv_valid_i) begin
               nxt_cur.mode = nv_mode_i;
               nxt_cur.par = nv_parity_i;
               nxt_cur.stop2 = nv_stop2_i;
               nxt_cur.baud = nv_baud_i;
               nxt_cur.det = ssa_pkg::SSA_DET_DONE;
            end else begin
               nxt_cur.det = ssa_pkg::SSA_DET_SEEK;
            end
         end
         ssa_pkg::SSA_DET_SEEK: begin
            nxt_cur.baud = det_baud_i;
            if (cur_ff.auto_full) begin
               nxt_cur.mode = det_mode_i;
               nxt_cur.par = det_parity_i;
               nxt_cur.stop2 = det_stop2_i;
            end else begin
               nxt_cur.mode = ssa_pkg::SSA_MODE_BINARY;
               nxt_cur.par = ssa_pkg::SSA_PAR_NONE;
               nxt_cur.stop2 = 1'b0;
            end
            if (answer_o && req_ok_i) begin
               // Freeze what was used for the good request and store it
               nxt_cur.mode = cur_ff.mode;
               nxt_cur.par = cur_ff.par;
               nxt_cur.stop2 = cur_ff.stop2;
               nxt_cur.baud = cur_ff.baud;
               nxt_cur.save = 1'b1;
               nxt_cur.det = ssa_pkg::SSA_DET_DONE;
            end
         end
         ssa_pkg::SSA_DET_DONE: begin
            nxt_cur.det = ssa_pkg::SSA_DET_DONE;
         end
         default: begin
            nxt_cur.det = ssa_pkg::SSA_DET_INIT;
         end
      endcase
      if (cur_ff.det != ssa_pkg::SSA_DET_INIT) begin
         if (sw_moved) begin
            nxt_cur.pending = 1'b1;
            nxt_cur.settle = '0;
         end else if (cur_ff.pending) begin
            if (cur_ff.settle == `SSA_CNT_W'(SETTLE_CYC - 1)) begin
               nxt_cur.pending = 1'b0;
               nxt_cur.active = address_switch_bank_i;
               nxt_cur.ok = sw_ok;
            end else begin
               nxt_cur.settle = cur_ff.settle + `SSA_CNT_W'(1);
            end
         end
      end
      // Free-running blink phase; LED lit only for the short on part
      if (cur_ff.blink == `SSA_CNT_W'(BLINK_CYC - 1)) begin
         nxt_cur.blink = '0;
      end else begin
         nxt_cur.blink = cur_ff.blink + `SSA_CNT_W'(1);
      end
      // No flash in the start-up cycle, before the address has been judged
      nxt_cur.led = !cur_ff.ok && (cur_ff.det != ssa_pkg::SSA_DET_INIT) &&
                    (cur_ff.blink < `SSA_CNT_W'(BLINK_ON_CYC));
   end

   // ==========================================================
   // State register
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ==========================================================
   // Outputs
   // Answer is gated the same cycle so a moved switch silences the old address at once
   assign answer_o = req_valid_i && (req_addr_i == cur_ff.active) && cur_ff.ok &&
                     !cur_ff.pending && !sw_moved && line_ok &&
                     (cur_ff.det != ssa_pkg::SSA_DET_INIT);
   assign led_red_o = cur_ff.led;
   assign disp_addr_o = cur_ff.active;
   assign disp_err_o = !cur_ff.ok && (cur_ff.det != ssa_pkg::SSA_DET_INIT);
   assign detecting_o = cur_ff.det == ssa_pkg::SSA_DET_SEEK;
   assign cfg_mode_o = cur_ff.mode;
   assign cfg_parity_o = cur_ff.par;
   assign cfg_stop2_o = cur_ff.stop2;
   assign cfg_baud_o = cur_ff.baud;
   assign cfg_data_bits_o = dbits;
   assign cfg_legal_o = line_ok;
   assign nv_save_o = cur_ff.save;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_good_req;
      detecting_o && answer_o && req_ok_i;
   endsequence
   sequence s_stored;
      nv_save_o && !detecting_o;
   endsequence

   a_addr_range: assert property (answer_o |->
         (disp_addr_o >= `SSA_ADDR_MIN && disp_addr_o <= `SSA_ADDR_MAX))
      else $error("answer given for an out-of-range address");
   a_stop_change: assert property ($changed(address_switch_bank_i) |-> !answer_o)
      else $error("answer given while the switches just moved");
   a_apply_late: assert property ($changed(address_switch_bank_i) && $past(rst_n_i)
         |=> disp_addr_o == $past(disp_addr_o))
      else $error("address taken without settling");
   a_led_quiet: assert property (!disp_err_o && $past(!disp_err_o) && cur_ff.ok
         && $past(cur_ff.ok) |-> !led_red_o)
      else $error("red LED lit with a valid address");
   a_disp_err: assert property (cur_ff.det != ssa_pkg::SSA_DET_INIT |->
         disp_err_o == !(disp_addr_o >= `SSA_ADDR_MIN && disp_addr_o <= `SSA_ADDR_MAX))
      else $error("display error does not match address validity");
   a_err_first: assert property ($rose(cur_ff.det != ssa_pkg::SSA_DET_INIT) && !cur_ff.ok |-> disp_err_o)
      else $error("invalid power-on address not flagged");
   a_fixed_8n1: assert property (detecting_o && !cur_ff.auto_full && $past(detecting_o)
         |-> cfg_mode_o == ssa_pkg::SSA_MODE_BINARY && cfg_parity_o == ssa_pkg::SSA_PAR_NONE
             && !cfg_stop2_o)
      else $error("fixed 8N1 not applied with detection off");
   a_done_store: assert property (s_good_req |=> s_stored)
      else $error("detection did not finish and store");
   a_legal_line: assert property (answer_o |-> cfg_legal_o)
      else $error("answer given on an unsupported line setting");
   a_text_bits: assert property (cfg_mode_o == ssa_pkg::SSA_MODE_TEXT |-> cfg_data_bits_o == 4'h7)
      else $error("text framing without 7 data bits");
   a_bin_bits: assert property (cfg_mode_o == ssa_pkg::SSA_MODE_BINARY |-> cfg_data_bits_o == 4'h8)
      else $error("binary framing without 8 data bits");
   a_silent_bad: assert property (!cur_ff.ok |-> !answer_o)
      else $error("answer given with an invalid address");
endmodule // ssa_top
`default_nettype wire

// ==== design/ssa_consts.svh ====
// Purpose: Named constants for the station address and line setup front end
// Assumes: 10 MHz system clock
// Notes: Times are kept in their own units; cycle counts are derived in the top module
`ifndef SSA_CONSTS_SVH
`define SSA_CONSTS_SVH
`define SSA_CLK_HZ 10000000
`define SSA_ADDR_MIN 8'h01
`define SSA_ADDR_MAX 8'hf7
`define SSA_SETTLE_S 15
`define SSA_BLINK_PERIOD_MS 2000
`define SSA_BLINK_ON_MS 200
`define SSA_OPT_AUTODET_BIT 4
`define SSA_DBITS_BINARY 4'h8
`define SSA_DBITS_TEXT 4'h7
`define SSA_BAUD_CODES 3'h6
`define SSA_CNT_W 28
`endif

// ==== design/ssa_pkg.sv ====
// Purpose: Types shared by the station address and line setup front end
// Assumes: Constants come from ssa_consts.svh
// Notes: Baud code 0..5 means 9600, 19200, 38400, 57600, 76800, 115200
`include "ssa_consts.svh"
package ssa_pkg;
   typedef enum logic {SSA_MODE_BINARY, SSA_MODE_TEXT} ssa_mode_t;
   typedef enum logic [1:0] {SSA_PAR_NONE, SSA_PAR_EVEN, SSA_PAR_ODD} ssa_par_t;
   typedef enum logic [1:0] {SSA_DET_INIT, SSA_DET_SEEK, SSA_DET_DONE} ssa_det_t;
   typedef struct packed {
      ssa_det_t det;
      logic [7:0] last_sw;
      logic [7:0] active;
      logic ok;
      logic pending;
      logic [`SSA_CNT_W-1:0] settle;
      logic [`SSA_CNT_W-1:0] blink;
      logic led;
      logic auto_full;
      ssa_mode_t mode;
      ssa_par_t par;
      logic stop2;
      logic [2:0] baud;
      logic save;
   } ssa_state_t;
endpackage

// ==== design/ssa_line_check.sv ====
// Purpose: Judges whether a framing and rate setting is one the port supports
// Assumes: Pure combinational, used by the top module
// Notes: The 8N1 case is legal only when the caller allows it
`timescale 1ns/1ps
`default_nettype none
`include "ssa_consts.svh"
module ssa_line_check (
   // Setting under test
   input wire ssa_pkg::ssa_mode_t mode_i,
   input wire ssa_pkg::ssa_par_t parity_i,
   input wire logic stop2_i,
   input wire logic [2:0] baud_i,
   input wire logic allow_8n1_i,
   // Verdict
   output logic legal_o,
   output logic [3:0] data_bits_o
);
   logic par_ok;
   always_comb begin
      data_bits_o = (mode_i == ssa_pkg::SSA_MODE_TEXT) ? `SSA_DBITS_TEXT : `SSA_DBITS_BINARY;
      if (parity_i == ssa_pkg::SSA_PAR_NONE) begin
         par_ok = stop2_i || (allow_8n1_i && mode_i == ssa_pkg::SSA_MODE_BINARY);
      end else begin
         par_ok = !stop2_i && (parity_i != 2'h3);
      end
      legal_o = par_ok && (baud_i < `SSA_BAUD_CODES);
   end
endmodule // ssa_line_check
`default_nettype wire

// ==== tb/ssa_master.sv ====
// Purpose: Bus master model that polls the slave and sets the line format
// Assumes: Tasks are entered 1 ns after a rising clock edge
// Notes: A released address line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module ssa_master (
   // Clock and answer
   input wire logic clock_i,
   input wire logic answer_i,
   // Request and line format
   output logic req_valid_o,
   output logic [7:0] req_addr_o,
   output logic req_ok_o,
   output var ssa_pkg::ssa_mode_t mode_o,
   output var ssa_pkg::ssa_par_t par_o,
   output logic stop2_o,
   output logic [2:0] baud_o
);
   initial begin
      req_valid_o = 1'b0;
      req_addr_o = 8'h00;
      req_ok_o = 1'b0;
   end
   // Any format and rate is sent as given, supported or not
   task automatic set_line(input ssa_pkg::ssa_mode_t m, input ssa_pkg::ssa_par_t p,
      input logic s, input logic [2:0] b);
      mode_o = m;
      par_o = p;
      stop2_o = s;
      baud_o = b;
   endtask
   // One request frame, one cycle long; the answer is taken at the edge that takes the request
   task automatic poll(input logic [7:0] a, input logic ok, output logic ans);
      req_valid_o = 1'b1;
      req_addr_o = a;
      req_ok_o = ok;
      @(posedge clock_i);
      ans = answer_i;
      #1 req_valid_o = 1'b0;
      req_addr_o = ~a;
      req_ok_o = ~ok;
   endtask
endmodule // ssa_master
`default_nettype wire

// ==== tb/ssa_top_bench.sv ====
// Purpose: Self-checking bench for the station address and line setup front end
// Assumes: Settle 20, blink period 16 and on time 4 cycles
// Notes: Line format cases each start from a fresh reset
`timescale 1ns/1ps
`default_nettype none
module ssa_top_bench;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] sw = 8'h05;
   logic [7:0] opt = 8'h10;
   logic nv_valid = 1'b0;
   logic answer, led, derr, detecting, stop2, legal, save, req_valid, req_ok, m_stop2, ans;
   logic [7:0] daddr, req_addr;
   logic [2:0] baud, m_baud;
   logic [3:0] dbits;
   ssa_pkg::ssa_mode_t mode, m_mode;
   ssa_pkg::ssa_par_t par, m_par;
   int error_cnt = 0;
   int n_checks = 0;
   int cycles = 0;
   int ones;
   ssa_top #(.SETTLE_CYC(20), .BLINK_CYC(16), .BLINK_ON_CYC(4)) i_ssa_top (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .address_switch_bank_i(sw),
      .option_switch_bank_i(opt), .nv_valid_i(nv_valid), .nv_mode_i(ssa_pkg::SSA_MODE_TEXT),
      .nv_parity_i(ssa_pkg::SSA_PAR_EVEN), .nv_stop2_i(1'b0), .nv_baud_i(3'h3),
      .det_mode_i(m_mode), .det_parity_i(m_par), .det_stop2_i(m_stop2), .det_baud_i(m_baud),
      .req_valid_i(req_valid), .req_addr_i(req_addr), .req_ok_i(req_ok), .answer_o(answer),
      .led_red_o(led), .disp_addr_o(daddr), .disp_err_o(derr), .detecting_o(detecting),
      .cfg_mode_o(mode), .cfg_parity_o(par), .cfg_stop2_o(stop2), .cfg_baud_o(baud),
      .cfg_data_bits_o(dbits), .cfg_legal_o(legal), .nv_save_o(save));
   ssa_master i_ssa_master (
      .clock_i(clock_i), .answer_i(answer), .req_valid_o(req_valid), .req_addr_o(req_addr),
      .req_ok_o(req_ok), .mode_o(m_mode), .par_o(m_par), .stop2_o(m_stop2), .baud_o(m_baud));
   initial begin
      forever #50 clock_i = ~clock_i;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic rst(input logic [7:0] s, input logic [7:0] o, input logic v);
      rst_n_i = 1'b0;
      sw = s;
      opt = o;
      nv_valid = v;
      cyc(20);
      rst_n_i = 1'b1;
      cyc(4);
   endtask
   // Fresh start with a detector guess, then the format in use is compared
   task automatic fmt(input logic [7:0] o, input ssa_pkg::ssa_mode_t m,
      input ssa_pkg::ssa_par_t p, input logic s, input logic [2:0] b, input logic [7:0] em,
      input logic [7:0] ep, input logic [7:0] es, input logic [7:0] eb, input logic [7:0] el);
      i_ssa_master.set_line(m, p, s, b);
      rst(8'h05, o, 1'b0);
      chk(mode, em);
      chk(par, ep);
      chk(stop2, es);
      chk(baud, {5'h00, b});
      chk(dbits, eb);
      chk(legal, el);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // A hang is cut short well beyond the expected few hundred cycles
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      i_ssa_master.set_line(ssa_pkg::SSA_MODE_BINARY, ssa_pkg::SSA_PAR_EVEN, 1'b0, 3'h2);
      rst(8'h05, 8'h10, 1'b0);
      chk(daddr, 8'h05);
      chk(derr, 8'h00);
      chk(detecting, 8'h01);
      i_ssa_master.poll(8'h06, 1'b1, ans);
      chk(ans, 8'h00);
      cyc(1);
      i_ssa_master.poll(8'h05, 1'b1, ans);
      chk(ans, 8'h01);
      #40 chk(save, 8'h01);
      chk(detecting, 8'h00);
      $display("test power-on and detection done");
      cyc(1);
      chk(save, 8'h00);
      sw = 8'h80;
      i_ssa_master.poll(8'h05, 1'b1, ans);
      chk(ans, 8'h00);
      cyc(10);
      sw = 8'hf8;
      // The change is seen at the next edge; the new address lands exactly 20 edges later
      cyc(20);
      chk(daddr, 8'h05);
      cyc(1);
      chk(daddr, 8'hf8);
      chk(derr, 8'h01);
      i_ssa_master.poll(8'hf8, 1'b1, ans);
      chk(ans, 8'h00);
      ones = 0;
      repeat (16) begin
         cyc(1);
         ones += led;
      end
      chk(ones[7:0], 8'h04);
      sw = 8'hf7;
      cyc(23);
      chk(derr, 8'h00);
      i_ssa_master.poll(8'hf7, 1'b1, ans);
      chk(ans, 8'h01);
      $display("test address change done");
      rst(8'h00, 8'h10, 1'b0);
      chk(derr, 8'h01);
      i_ssa_master.poll(8'h00, 1'b1, ans);
      chk(ans, 8'h00);
      $display("test invalid at power-on done");
      fmt(8'h10, ssa_pkg::SSA_MODE_TEXT, ssa_pkg::SSA_PAR_ODD, 1'b0, 3'h4, 1, 2, 0, 7, 1);
      fmt(8'h10, ssa_pkg::SSA_MODE_BINARY, ssa_pkg::SSA_PAR_NONE, 1'b1, 3'h5, 0, 0, 1, 8, 1);
      fmt(8'h10, ssa_pkg::SSA_MODE_BINARY, ssa_pkg::SSA_PAR_NONE, 1'b0, 3'h0, 0, 0, 0, 8, 0);
      fmt(8'h10, ssa_pkg::SSA_MODE_TEXT, ssa_pkg::SSA_PAR_EVEN, 1'b0, 3'h6, 1, 1, 0, 7, 0);
      fmt(8'h00, ssa_pkg::SSA_MODE_TEXT, ssa_pkg::SSA_PAR_EVEN, 1'b1, 3'h1, 0, 0, 0, 8, 1);
      $display("test line formats done");
      rst(8'h05, 8'h10, 1'b1);
      chk(mode, 8'h01);
      chk(baud, 8'h03);
      chk(detecting, 8'h00);
      $display("test stored setup done");
      conclude();
   end
endmodule // ssa_top_bench
`default_nettype wire
